// file: hw/dcfifo_pkg.sv
// Purpose: Shared constants and types for the deep 18-bit queue block
// Assumes: Single 100 MHz clock, synchronous active-high reset
// Notes: Offsets are held as word counts at the queue's address width
package dcfifo_pkg;
    localparam int DCF_DATA_W = 18;
    localparam int DCF_DEPTH = 32768;
    localparam int DCF_ADDR_W = $clog2(DCF_DEPTH);
    localparam int DCF_PTR_W = DCF_ADDR_W + 1;
    localparam logic [DCF_PTR_W-1:0] DCF_DEPTH_CNT = DCF_PTR_W'(DCF_DEPTH);
    localparam logic [DCF_PTR_W-1:0] DCF_HALF_CNT = DCF_PTR_W'(DCF_DEPTH / 2);
    localparam int DCF_BUF_DEPTH = 16;
    localparam int DCF_BUF_LVL_W = $clog2(DCF_BUF_DEPTH) + 1;
    localparam logic [DCF_ADDR_W-1:0] DCF_AE_OFF_RST = 15'h007F;
    localparam logic [DCF_ADDR_W-1:0] DCF_AF_OFF_RST = 15'h007F;

    typedef logic [DCF_DATA_W-1:0] dcf_word_t;

    typedef struct packed {
        logic empty_n;
        logic almost_empty_n;
        logic half_full;
        logic almost_full_n;
        logic full_n;
    } dcf_flags_t;

    typedef struct packed {
        logic [DCF_ADDR_W-1:0] empty_off;
        logic [DCF_ADDR_W-1:0] full_off;
    } dcf_offsets_t;
endpackage

// file: hw/dcfifo_top.sv
// Purpose: Deep 18-bit queue with fill flags, offset register and depth cascade
// Assumes: Writer and reader logic run on i_clk; write and read clocks tied together
// Notes: A 16-word prefetch buffer sits between the main array and the read port
`timescale 1ns/1ps

module dcfifo_buf #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;
    wire logic push = i_in_valid && o_in_ready;
    wire logic pop = o_out_valid && i_out_ready;

    assign o_level = wr_reg - rd_reg;
    assign o_in_ready = (o_level != (AW+1)'(DEPTH));
    assign o_out_valid = (wr_reg != rd_reg);
    assign o_out_data = mem[rd_reg[AW-1:0]];

    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem[wr_reg[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
        end
        else
        begin
            wr_reg <= wr_reg + (AW+1)'(push);
            rd_reg <= rd_reg + (AW+1)'(pop);
        end
    end
endmodule

module dcfifo_top
    import dcfifo_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire dcf_word_t i_data,
    input wire logic i_write_enable_n,
    input wire logic i_read_enable_n,
    input wire logic i_offset_load_select_n,
    input wire logic i_output_enable_n,
    input wire logic i_almost_flag_sync_strap,
    input wire logic i_depth_cascade,
    input wire logic i_first_load_strap,
    input wire logic i_write_expansion_in,
    input wire logic i_read_expansion_in,
    output dcf_word_t o_data,
    output logic o_data_oe,
    output logic o_empty_flag_n,
    output logic o_full_flag_n,
    output logic o_almost_empty_flag_n,
    output logic o_almost_full_flag_n,
    output logic o_half_full_flag,
    output logic o_read_expansion_out
);
    logic [DCF_DATA_W-1:0] mem [DCF_DEPTH];

    function automatic logic [DCF_PTR_W-1:0] gray2bin(input logic [DCF_PTR_W-1:0] g);
        logic [DCF_PTR_W-1:0] b;
        b = '0;
        for (int i = DCF_PTR_W - 1; i >= 0; i--)
        begin
            b[i] = g[i] ^ ((i == DCF_PTR_W - 1) ? 1'b0 : b[i+1]);
        end
        return b;
    endfunction

    logic [DCF_PTR_W-1:0] wptr_reg;
    logic [DCF_PTR_W-1:0] rptr_reg;
    logic [DCF_PTR_W-1:0] wgray_reg;
    logic [DCF_PTR_W-1:0] rgray_reg;
    logic [DCF_PTR_W-1:0] wgray_s1_reg;
    logic [DCF_PTR_W-1:0] wgray_s2_reg;
    logic [DCF_PTR_W-1:0] rgray_s1_reg;
    logic [DCF_PTR_W-1:0] rgray_s2_reg;
    dcf_offsets_t off_reg;
    logic wr_sel_reg;
    logic rd_sel_reg;
    logic wr_token_reg;
    logic rd_token_reg;
    logic wxo_reg;
    dcf_flags_t flags_reg;
    dcf_flags_t flags_next;
    dcf_word_t data_reg;
    logic oe_reg;
    logic rxo_reg;
    logic hf_pin_reg;

    // Write side decode
    wire logic wr_req = !i_write_enable_n;
    wire logic ld_active = !i_offset_load_select_n;
    wire logic wr_allowed = !i_depth_cascade || wr_token_reg;
    wire logic [DCF_PTR_W-1:0] rptr_at_wr = gray2bin(rgray_s2_reg);
    wire logic [DCF_PTR_W-1:0] wr_level = wptr_reg - rptr_at_wr;
    wire logic wr_full = (wr_level == DCF_DEPTH_CNT);
    wire logic do_load = wr_req && ld_active;
    wire logic do_store = wr_req && !ld_active && !wr_full && wr_allowed;
    wire logic [DCF_PTR_W-1:0] wr_level_new = wr_level + DCF_PTR_W'(do_store);
    wire logic last_slot = do_store && (wr_level_new == DCF_DEPTH_CNT);

    // Read side: main array feeds the prefetch buffer
    wire logic [DCF_PTR_W-1:0] wptr_at_rd = gray2bin(wgray_s2_reg);
    wire logic [DCF_PTR_W-1:0] rd_main_level = wptr_at_rd - rptr_reg;
    wire logic main_has = (rd_main_level != '0);
    logic buf_ready;
    logic buf_valid;
    dcf_word_t buf_data;
    logic [DCF_BUF_LVL_W-1:0] buf_level;
    wire logic fill = main_has && buf_ready;
    wire logic rd_req = !i_read_enable_n;
    wire logic rd_allowed = !i_depth_cascade || rd_token_reg;
    wire logic do_pop = rd_req && !ld_active && flags_reg.empty_n && buf_valid
        && rd_allowed;
    wire logic do_offrd = rd_req && ld_active;

    dcfifo_buf #(
        .WIDTH(DCF_DATA_W),
        .DEPTH(DCF_BUF_DEPTH)
    ) u_buf (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(main_has),
        .o_in_ready(buf_ready),
        .i_in_data(mem[rptr_reg[DCF_ADDR_W-1:0]]),
        .o_out_valid(buf_valid),
        .i_out_ready(do_pop),
        .o_out_data(buf_data),
        .o_level(buf_level)
    );

    // Fill levels after this cycle's moves, as each side sees them
    wire logic [DCF_PTR_W-1:0] buf_after =
        DCF_PTR_W'(buf_level) - DCF_PTR_W'(do_pop);
    wire logic [DCF_PTR_W-1:0] rd_level_new = rd_main_level + buf_after;
    // Direct count: valid only because both sides share i_clk
    wire logic [DCF_PTR_W-1:0] live_level =
        (wptr_reg + DCF_PTR_W'(do_store)) - rptr_reg + buf_after;
    wire logic use_sync = !i_almost_flag_sync_strap;
    wire logic [DCF_PTR_W-1:0] ae_level = use_sync ? rd_level_new : live_level;
    wire logic [DCF_PTR_W-1:0] af_level = use_sync ? wr_level_new : live_level;
    wire logic [DCF_PTR_W-1:0] af_limit = DCF_DEPTH_CNT - DCF_PTR_W'(off_reg.full_off);
    wire logic empty_after = (rd_level_new == '0);
    wire logic wxo_next = i_depth_cascade && last_slot && wr_token_reg;
    wire logic hf_pin_next = i_depth_cascade ? wxo_next : flags_next.half_full;

    always_comb
    begin
        flags_next.empty_n = !(buf_after == '0);
        flags_next.almost_empty_n = !(ae_level <= DCF_PTR_W'(off_reg.empty_off));
        flags_next.half_full = (wr_level_new > DCF_HALF_CNT);
        flags_next.almost_full_n = !(af_level >= af_limit);
        flags_next.full_n = !(wr_level_new == DCF_DEPTH_CNT);
    end

    // Main array write port
    always_ff @(posedge i_clk)
    begin
        if (do_store)
        begin
            mem[wptr_reg[DCF_ADDR_W-1:0]] <= i_data;
        end
    end

    // Pointers and gray crossing
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            wgray_reg <= '0;
            rgray_reg <= '0;
            wgray_s1_reg <= '0;
            wgray_s2_reg <= '0;
            rgray_s1_reg <= '0;
            rgray_s2_reg <= '0;
        end
        else
        begin
            wptr_reg <= wptr_reg + DCF_PTR_W'(do_store);
            rptr_reg <= rptr_reg + DCF_PTR_W'(fill);
            wgray_reg <= wptr_reg ^ (wptr_reg >> 1);
            rgray_reg <= rptr_reg ^ (rptr_reg >> 1);
            wgray_s1_reg <= wgray_reg;
            wgray_s2_reg <= wgray_s1_reg;
            rgray_s1_reg <= rgray_reg;
            rgray_s2_reg <= rgray_s1_reg;
        end
    end

    // Offset register: loads and reads alternate empty then full offset
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            off_reg.empty_off <= DCF_AE_OFF_RST;
            off_reg.full_off <= DCF_AF_OFF_RST;
            wr_sel_reg <= 1'b0;
            rd_sel_reg <= 1'b0;
        end
        else
        begin
            if (do_load)
            begin
                if (wr_sel_reg)
                begin
                    off_reg.full_off <= i_data[DCF_ADDR_W-1:0];
                end
                else
                begin
                    off_reg.empty_off <= i_data[DCF_ADDR_W-1:0];
                end
                wr_sel_reg <= !wr_sel_reg;
            end
            if (do_offrd)
            begin
                rd_sel_reg <= !rd_sel_reg;
            end
        end
    end

    // Cascade tokens: first device starts with both, passes them on when it fills or drains
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            wr_token_reg <= 1'b0;
            rd_token_reg <= 1'b0;
            wxo_reg <= 1'b0;
            rxo_reg <= 1'b0;
        end
        else
        begin
            wxo_reg <= wxo_next;
            rxo_reg <= i_depth_cascade && do_pop && rd_token_reg && empty_after;
            if (!i_depth_cascade)
            begin
                wr_token_reg <= 1'b0;
                rd_token_reg <= 1'b0;
            end
            else
            begin
                // Token set on arrival wins over any pass in the same cycle
                wr_token_reg <= i_write_expansion_in || (wr_token_reg && !last_slot)
                    || (!i_first_load_strap && wptr_reg == '0 && !wxo_reg
                        && !wr_token_reg && wr_level == '0 && rptr_reg == '0);
                rd_token_reg <= i_read_expansion_in
                    || (rd_token_reg && !(do_pop && empty_after))
                    || (!i_first_load_strap && rptr_reg == '0 && !rxo_reg
                        && buf_level == '0 && !rd_token_reg);
            end
        end
    end

    // Flags and output port
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            flags_reg <= '{empty_n: 1'b0, almost_empty_n: 1'b0, half_full: 1'b0,
                           almost_full_n: 1'b1, full_n: 1'b1};
            data_reg <= '0;
            oe_reg <= 1'b0;
            hf_pin_reg <= 1'b0;
        end
        else
        begin
            flags_reg <= flags_next;
            hf_pin_reg <= hf_pin_next;
            oe_reg <= !i_output_enable_n;
            if (do_offrd)
            begin
                data_reg <= DCF_DATA_W'(rd_sel_reg ? off_reg.full_off : off_reg.empty_off);
            end
            else if (do_pop)
            begin
                data_reg <= buf_data;
            end
        end
    end

    assign o_data = data_reg;
    assign o_data_oe = oe_reg;
    assign o_empty_flag_n = flags_reg.empty_n;
    assign o_full_flag_n = flags_reg.full_n;
    assign o_almost_empty_flag_n = flags_reg.almost_empty_n;
    assign o_almost_full_flag_n = flags_reg.almost_full_n;
    // Shared pin: expansion pulse in cascade, half full otherwise
    assign o_half_full_flag = hf_pin_reg;
    assign o_read_expansion_out = rxo_reg;
endmodule

// file: verif/dcfifo_reader.sv
// Purpose: Reader logic on the far side of the read port
// Assumes: Same clock as the queue
// Notes: Reads every other cycle so each decision sees a settled empty flag
`timescale 1ns/1ps
module dcfifo_reader
    import dcfifo_pkg::*;
(
    input wire logic i_clk,
    input wire logic [15:0] i_budget,
    input wire logic i_any,
    input wire logic i_empty_flag_n,
    input wire dcf_word_t i_q,
    output logic o_read_enable_n = 1'b1,
    output logic o_valid = 1'b0,
    output dcf_word_t o_word = 18'h00000
);
    logic [15:0] count_reg = 16'h0000;
    logic pend_reg = 1'b0;
    wire logic taken = !o_read_enable_n && (i_empty_flag_n || i_any);
    always_ff @(posedge i_clk)
    begin
        pend_reg <= taken;
        count_reg <= count_reg + 16'(taken);
        o_read_enable_n <= !(o_read_enable_n && count_reg != i_budget);
        o_valid <= pend_reg;
        o_word <= i_q;
    end
endmodule

// file: verif/dcfifo_top_assertions.sv
// Purpose: Port-level checker for dcfifo_top
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every dcfifo_top instance
`timescale 1ns/1ps
module dcfifo_top_assertions
    import dcfifo_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_write_enable_n,
    input wire logic i_read_enable_n,
    input wire logic i_offset_load_select_n,
    input wire logic i_output_enable_n,
    input wire logic i_depth_cascade,
    input wire dcf_word_t o_data,
    input wire logic o_data_oe,
    input wire logic o_empty_flag_n,
    input wire logic o_full_flag_n,
    input wire logic o_almost_empty_flag_n,
    input wire logic o_almost_full_flag_n,
    input wire logic o_half_full_flag,
    input wire logic o_read_expansion_out
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Reset itself is the cause here, so this one is never disabled
    chk_reset_state: assert property (disable iff (1'b0) i_rst |=> !o_empty_flag_n
        && o_full_flag_n && o_almost_full_flag_n && !o_data_oe && !o_half_full_flag)
        else $error("flags or enable wrong after reset");
    chk_oe_delay: assert property (1'b1 |=> o_data_oe == !$past(i_output_enable_n))
        else $error("output enable does not follow its input");
    chk_data_hold: assert property (i_read_enable_n |=> $stable(o_data))
        else $error("read data changed without a read");
    chk_full_flags: assert property (!o_full_flag_n && !i_depth_cascade
        |-> !o_almost_full_flag_n && o_half_full_flag)
        else $error("full without almost full and half full");
    chk_write_fills: assert property (!i_write_enable_n && i_offset_load_select_n
        && !i_depth_cascade |-> ##[1:8] o_empty_flag_n)
        else $error("written word never became readable");
    chk_half_cause: assert property ($rose(o_half_full_flag) && !i_depth_cascade
        |-> !$past(i_write_enable_n) || !$past(i_write_enable_n, 2))
        else $error("half full rose without a write");
    chk_empty_cause: assert property ($fell(o_empty_flag_n) |-> !$past(i_read_enable_n)
        || !$past(i_read_enable_n, 2) || $past(i_rst))
        else $error("empty flag fell without a read");
    chk_rx_quiet: assert property (!i_depth_cascade |-> !o_read_expansion_out)
        else $error("read expansion pulse outside cascade");
    chk_full_hold: assert property (i_read_enable_n [*8] ##0 !o_full_flag_n
        |=> !o_full_flag_n)
        else $error("full flag cleared with no reads");
    cover property ($rose(o_empty_flag_n));
    cover property (!o_full_flag_n);
    cover property ($rose(o_almost_empty_flag_n));
    cover property (!i_offset_load_select_n && !i_read_enable_n);
endmodule

bind dcfifo_top dcfifo_top_assertions dcfifo_top_assertions_i (.*);

// file: verif/dcfifo_top_tb.sv
// Purpose: Self-checking bench for dcfifo_top
// Assumes: Cascade pins close a ring of one device, used when cascade mode is set
// Notes: Full test writes past depth plus prefetch to force drops
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; $display("Error at %0t: got %h expected %h", $time, a, b); end end
module dcfifo_top_tb;
    import dcfifo_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic wen_n = 1'b1, ld_n = 1'b1, oe_n = 1'b1, strap = 1'b0, any = 1'b0, casc = 1'b0;
    logic ren_n, got_v, ef_n, ff_n, ae_n, af_n, hf, oe, read_expansion_out;
    logic [15:0] budget = 16'h0000;
    dcf_word_t i_data = 18'h00000;
    dcf_word_t q, got_w;
    dcf_word_t got[$];
    int n_mismatch = 0;
    int samples_checked = 0;
    int i, s;
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) if (got_v) got.push_back(got_w);
    dcfifo_top dcfifo_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_data(i_data),
        .i_write_enable_n(wen_n), .i_read_enable_n(ren_n), .i_offset_load_select_n(ld_n),
        .i_output_enable_n(oe_n), .i_almost_flag_sync_strap(strap), .i_depth_cascade(casc),
        // Ring of one: this device is both the first and the last of its cascade
        .i_first_load_strap(1'b0),
        .i_write_expansion_in(hf && casc), .i_read_expansion_in(read_expansion_out),
        .o_data(q), .o_data_oe(oe), .o_empty_flag_n(ef_n), .o_full_flag_n(ff_n),
        .o_almost_empty_flag_n(ae_n), .o_almost_full_flag_n(af_n), .o_half_full_flag(hf),
        .o_read_expansion_out(read_expansion_out));
    dcfifo_reader dcfifo_reader_i (.i_clk(i_clk), .i_budget(budget), .i_any(any),
        .i_empty_flag_n(ef_n), .i_q(q), .o_read_enable_n(ren_n), .o_valid(got_v), .o_word(got_w));
    task tally_and_finish;
        $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task wr(input dcf_word_t d, input logic l);
        @(posedge i_clk);
        wen_n <= 1'b0;
        i_data <= d;
        ld_n <= l;
    endtask
    task idle(input int n);
        repeat (n)
        begin
            @(posedge i_clk);
            wen_n <= 1'b1;
            ld_n <= 1'b1;
        end
        #1;
    endtask
    task wait_got(input int n);
        int k;
        for (k = 0; k < 600 && got.size() < n; k++) @(posedge i_clk);
        if (got.size() < n)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    // Load-select reads bypass the empty flag, so the reader is told to ignore it
    task rd(input int n, input logic l);
        got.delete();
        @(posedge i_clk);
        any <= l;
        ld_n <= !l;
        budget <= budget + 16'(n);
        wait_got(n);
        any <= 1'b0;
        ld_n <= 1'b1;
    endtask
    task rst_pulse(input logic sm, input logic cm);
        @(posedge i_clk);
        i_rst <= 1'b1;
        strap <= sm;
        casc <= cm;
        @(posedge i_clk);
        i_rst <= 1'b0;
    endtask
    initial
    begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        oe_n <= 1'b0;
        idle(2);
        `CHK(ef_n, 1'b0)
        `CHK(ff_n, 1'b1)
        `CHK(ae_n, 1'b0)
        `CHK(oe, 1'b1)
        @(posedge i_clk);
        oe_n <= 1'b1;
        idle(2);
        `CHK(oe, 1'b0)
        $display("Test reset_oe done");
        got.delete();
        @(posedge i_clk);
        budget <= budget + 16'h0010;
        for (i = 0; i < 16; i++) wr(18'h15000 + 18'(i), 1'b1);
        idle(1);
        wait_got(16);
        for (i = 0; i < 16; i++) `CHK(got[i], 18'h15000 + 18'(i))
        $display("Test stream done");
        for (s = 0; s < 2; s++)
        begin
            rst_pulse(s[0], 1'b0);
            wr(18'h00002, 1'b0);
            wr(18'h0007F, 1'b0);
            idle(1);
            rd(2, 1'b1);
            `CHK(got[0], 18'h00002)
            `CHK(got[1], 18'h0007F)
            for (i = 0; i < 4; i++) wr(18'h2A000 + 18'(i), 1'b1);
            idle(12);
            `CHK(ae_n, 1'b1)
            rd(2, 1'b0);
            `CHK(got[1], 18'h2A001)
            idle(8);
            `CHK(ae_n, 1'b0)
        end
        $display("Test offsets done");
        rst_pulse(1'b0, 1'b1);
        for (i = 0; i < 4; i++) wr(18'h3C000 + 18'(i), 1'b1);
        idle(12);
        `CHK(hf, 1'b0)
        `CHK(ef_n, 1'b1)
        rd(4, 1'b0);
        for (i = 0; i < 4; i++) `CHK(got[i], 18'h3C000 + 18'(i))
        idle(4);
        `CHK(ef_n, 1'b0)
        $display("Test cascade done");
        rst_pulse(1'b0, 1'b0);
        for (i = 0; i < 32800; i++) wr(18'(i), 1'b1);
        idle(8);
        `CHK(ff_n, 1'b0)
        `CHK(hf, 1'b1)
        `CHK(af_n, 1'b0)
        rd(20, 1'b0);
        for (i = 0; i < 20; i++) `CHK(got[i], 18'(i))
        idle(10);
        `CHK(ff_n, 1'b1)
        $display("Test full done");
        tally_and_finish();
    end
endmodule
